// File: hdl/exp_cfg_pkg.sv
/*
 * Shared types and constants for the expansion bus configuration block:
 * chip-select control layout, strap register layout, map and reset values.
 * Assumes word-wide register accesses only.
 */
package exp_cfg_pkg;

    localparam int NUM_CS = 4;
    localparam int STRAP_W = 24;
    localparam int CLKSET_LO = 21;
    localparam logic [31:0] CS_TIMING_ADDR = 32'hC400_0000;
    localparam logic [31:0] STRAP_CFG0_ADDR = 32'hC400_0020;
    localparam logic [31:0] CS_WR_MASK = 32'hBFFF_7D5B;
    localparam logic [31:0] CFG0_WR_MASK = 32'h801E_07B7;
    localparam logic [31:0] CS0_RESET = 32'hBFFF_3C00;
    localparam logic [31:0] CS_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG0_RESET = 32'h8000_0100;
    localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
    localparam logic [31:0] NORMAL_BASE = 32'h5000_0000;
    localparam logic [31:0] WINDOW_MASK = 32'hF000_0000;
    localparam logic [4:0] SIZE_LOG2_BASE = 5'h09;
    localparam logic [3:0] BASE_PHASE_CYCLES = 4'h1;

    typedef struct packed {
        logic region_select_on;
        logic check_bit_option;
        logic [1:0] address_phase_stretch;
        logic [1:0] setup_phase_stretch;
        logic [3:0] strobe_phase_stretch;
        logic [1:0] hold_phase_stretch;
        logic [3:0] recovery_phase_stretch;
        logic cycle_style_hi;
        logic bus_cycle_style;
        logic [3:0] region_size_code;
        logic size_hi;
        logic sync_flash;
        logic peer_chip;
        logic narrow_read_on_halfword;
        logic rsvd5;
        logic shared_addr_data_bus;
        logic split_response_allow;
        logic wide_bus;
        logic write_allow;
        logic narrow_bus;
    } cs_ctrl_t;

    typedef struct packed {
        logic mem_map_boot;
        logic [6:0] rsvd_hi;
        logic [2:0] clock_set;
        logic [3:0] customer;
        logic [4:0] rsvd_mid;
        logic ddr_mode;
        logic wait_sample_sel0;
        logic drive_hi;
        logic usb_clk_internal;
        logic flash_32;
        logic rsvd6;
        logic drive_lo;
        logic pci_clk;
        logic rsvd3;
        logic pci_arbiter_on;
        logic pci_host;
        logic flash_8bit;
    } strap_cfg_t;

    typedef enum logic [1:0] {SPEED_400, SPEED_533, SPEED_667} speed_t;

    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_SETUP, PH_STROBE, PH_HOLD, PH_RECOV} phase_t;

endpackage

// File: hdl/exp_cfg_ctrl.sv
/*
 * Expansion bus configuration block: four chip-select timing and control
 * registers, the reset strap register and a phase sequencer that runs
 * one expansion bus access per request.
 * Assumes a synchronous word-wide register port and synchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none

module exp_cfg_ctrl #(
    parameter exp_cfg_pkg::speed_t FACTORY_SPEED = exp_cfg_pkg::SPEED_667
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reset sequencing
    input wire logic pll_lock,
    input wire logic cold_reset_n,
    // Register port
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // Access request port
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_error,
    output logic acc_split,
    output logic [15:0] acc_rdata,
    // Expansion bus pins
    input wire logic [23:0] expansion_address_pins_in,
    output logic [23:0] expansion_address_pins_out,
    output logic expansion_address_pins_oe,
    input wire logic [15:0] exp_data_in,
    output logic [15:0] exp_data_out,
    output logic exp_data_oe,
    output logic [3:0] exp_cs_n,
    output logic exp_rd_n,
    output logic exp_wr_n,
    output logic exp_ale,
    input wire logic external_wait_input_n,
    // Configuration outputs
    output var exp_cfg_pkg::strap_cfg_t strap_cfg,
    output var exp_cfg_pkg::speed_t core_speed,
    output logic [1:0] exp_drive,
    output logic [31:0] exp_window_base
);
    import exp_cfg_pkg::*;

    typedef struct packed {
        cs_ctrl_t [NUM_CS-1:0] cs;
        strap_cfg_t cfg;
        speed_t speed;
        phase_t ph;
        logic [3:0] cnt;
        logic [1:0] sel;
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [31:0] rdata;
        logic ack;
        logic busy;
        logic done;
        logic error;
        logic split;
        logic [15:0] ardata;
        logic [3:0] cs_n;
        logic rd_n;
        logic wr_n;
        logic ale;
        logic addr_oe;
        logic [15:0] dout;
        logic doe;
        logic [31:0] win;
    } state_t;

    state_t s_q;
    state_t s_d;
    state_t rst_val;

    ////////////////////////////////////////////////////////////////////////
    // Reset image and helpers

    always_comb
    begin
        rst_val = '0;
        rst_val.cs = {NUM_CS{cs_ctrl_t'(CS_RESET)}};
        rst_val.cs[0] = cs_ctrl_t'(CS0_RESET);
        rst_val.cfg = strap_cfg_t'(CFG0_RESET);
        rst_val.speed = FACTORY_SPEED;
        rst_val.ph = PH_IDLE;
        rst_val.cs_n = 4'hF;
        rst_val.rd_n = 1'b1;
        rst_val.wr_n = 1'b1;
        rst_val.win = BOOT_BASE;
    end

    // The clock set straps can only pull the core below its grade.
    function automatic speed_t slow_core(input logic [2:0] set);
        speed_t r;
        r = FACTORY_SPEED;
        if (!set[2] && set[1:0] == 2'b01 && FACTORY_SPEED == SPEED_667)
        begin
            r = SPEED_533;
        end
        else if (!set[2] && set[1:0] == 2'b11)
        begin
            r = SPEED_400;
        end
        return r;
    endfunction

    // Length of a phase less one, so the counter ends at zero.
    function automatic logic [3:0] span(input logic [3:0] stretch);
        return 4'(stretch + BASE_PHASE_CYCLES - 4'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [31:0] bits;
        logic [24:0] limit;
        logic [1:0] slot;
        logic hit;
        logic wait_on;
        cs_ctrl_t c;
        bits = '0;
        limit = '0;
        slot = '0;
        hit = 1'b0;
        wait_on = 1'b0;
        c = '0;
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.done = 1'b0;
        s_d.addr_oe = pll_lock;

        // Register port: masked bits never take a written one.
        if (reg_req)
        begin
            s_d.ack = 1'b1;
            s_d.rdata = '0;
            for (int i = 0; i < NUM_CS; i++)
            begin
                if (reg_addr == CS_TIMING_ADDR + 32'(4 * i))
                begin
                    s_d.rdata = 32'(s_q.cs[i]);
                    if (reg_write)
                    begin
                        s_d.cs[i] = cs_ctrl_t'((32'(s_q.cs[i]) & ~CS_WR_MASK)
                            | (reg_wdata & CS_WR_MASK));
                    end
                end
            end
            if (reg_addr == STRAP_CFG0_ADDR)
            begin
                s_d.rdata = 32'(s_q.cfg);
                if (reg_write)
                begin
                    s_d.cfg = strap_cfg_t'((32'(s_q.cfg) & ~CFG0_WR_MASK)
                        | (reg_wdata & CFG0_WR_MASK));
                end
            end
        end

        // Strap capture while the PLL is unlocked; pins float as inputs.
        if (!pll_lock)
        begin
            bits = 32'(s_q.cfg);
            bits[31] = 1'b1;
            bits[30:STRAP_W] = '0;
            bits[CLKSET_LO-1:0] = expansion_address_pins_in[CLKSET_LO-1:0];
            if (!cold_reset_n)
            begin
                bits[STRAP_W-1:CLKSET_LO] = expansion_address_pins_in[STRAP_W-1:CLKSET_LO];
                s_d.speed = slow_core(expansion_address_pins_in[STRAP_W-1:CLKSET_LO]);
            end
            s_d.cfg = strap_cfg_t'(bits);
            s_d.cs[0].narrow_bus = expansion_address_pins_in[0];
        end

        // Window placement follows the map bit.
        s_d.win = s_d.cfg.mem_map_boot ? BOOT_BASE : NORMAL_BASE;

        // Decode: each select owns a 16 Mbyte slot of the window.
        slot = acc_addr[25:24];
        c = s_q.cs[slot];
        limit = 25'h000_0001 << (SIZE_LOG2_BASE + 5'(c.region_size_code));
        hit = ((acc_addr & WINDOW_MASK) == s_q.win) && (acc_addr[27:26] == 2'b00)
            && c.region_select_on
            && ({1'b0, acc_addr[23:0]} < limit);

        c = s_q.cs[s_q.sel];
        wait_on = !c.sync_flash
            && (s_q.sel != 2'b00 || c.bus_cycle_style || s_q.cfg.wait_sample_sel0);

        // Access sequencer; a nonzero count holds the current phase.
        if (s_q.cnt != 4'h0)
        begin
            s_d.cnt = 4'(s_q.cnt - 4'h1);
        end
        else
        begin
            unique case (s_q.ph)
                PH_IDLE:
                begin
                    if (acc_req && pll_lock)
                    begin
                        s_d.split = s_q.cs[slot].split_response_allow;
                        s_d.error = !hit || (acc_write && !s_q.cs[slot].write_allow);
                        s_d.done = s_d.error;
                        if (!s_d.error)
                        begin
                            s_d.sel = slot;
                            s_d.write = acc_write;
                            s_d.addr = acc_addr[23:0];
                            s_d.wdata = acc_wdata;
                            s_d.busy = 1'b1;
                            s_d.ph = PH_ADDR;
                            s_d.cnt = span(4'(s_q.cs[slot].address_phase_stretch));
                        end
                    end
                end
                PH_ADDR:
                begin
                    s_d.ph = PH_SETUP;
                    s_d.cnt = span(4'(c.setup_phase_stretch));
                end
                PH_SETUP:
                begin
                    s_d.ph = PH_STROBE;
                    s_d.cnt = span(c.strobe_phase_stretch);
                end
                PH_STROBE:
                begin
                    if (!(wait_on && !external_wait_input_n))
                    begin
                        s_d.ardata = c.narrow_bus ? {8'h00, exp_data_in[7:0]} : exp_data_in;
                        s_d.ph = PH_HOLD;
                        s_d.cnt = span(4'(c.hold_phase_stretch));
                    end
                end
                PH_HOLD:
                begin
                    s_d.ph = PH_RECOV;
                    s_d.cnt = span(c.recovery_phase_stretch);
                end
                PH_RECOV:
                begin
                    s_d.ph = PH_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
                default:
                begin
                    s_d.ph = PH_IDLE;
                end
            endcase
        end

        // Pin image for the phase being entered, so every pin is a flop.
        c = s_d.cs[s_d.sel];
        s_d.cs_n = 4'hF;
        s_d.rd_n = 1'b1;
        s_d.wr_n = 1'b1;
        s_d.ale = 1'b0;
        s_d.doe = 1'b0;
        s_d.dout = c.narrow_bus ? {8'h00, s_d.wdata[7:0]} : s_d.wdata;
        if (s_d.ph == PH_ADDR && c.shared_addr_data_bus)
        begin
            s_d.ale = 1'b1;
            s_d.doe = 1'b1;
            s_d.dout = s_d.addr[15:0];
        end
        if (s_d.ph == PH_SETUP || s_d.ph == PH_STROBE || s_d.ph == PH_HOLD)
        begin
            s_d.cs_n[s_d.sel] = 1'b0;
            s_d.doe = s_d.write;
            // Second style: one data strobe plus a read-not-write level.
            if (c.bus_cycle_style)
            begin
                s_d.wr_n = !s_d.write;
                s_d.rd_n = !(s_d.ph == PH_STROBE);
            end
            else
            begin
                s_d.rd_n = !(s_d.ph == PH_STROBE && !s_d.write);
                s_d.wr_n = !(s_d.ph == PH_STROBE && s_d.write);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= rst_val;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = s_q.rdata;
    assign reg_ack = s_q.ack;
    assign acc_busy = s_q.busy;
    assign acc_done = s_q.done;
    assign acc_error = s_q.error;
    assign acc_split = s_q.split;
    assign acc_rdata = s_q.ardata;
    assign expansion_address_pins_out = s_q.addr;
    assign expansion_address_pins_oe = s_q.addr_oe;
    assign exp_data_out = s_q.dout;
    assign exp_data_oe = s_q.doe;
    assign exp_cs_n = s_q.cs_n;
    assign exp_rd_n = s_q.rd_n;
    assign exp_wr_n = s_q.wr_n;
    assign exp_ale = s_q.ale;
    assign strap_cfg = s_q.cfg;
    assign core_speed = s_q.speed;
    assign exp_drive = {s_q.cfg.drive_hi, s_q.cfg.drive_lo};
    assign exp_window_base = s_q.win;

endmodule

`default_nettype wire

// File: test/exp_cfg_asserts.sv
/* Port checker for the expansion bus configuration block.
   Assumes it is bound into every instance of exp_cfg_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module exp_cfg_asserts (
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic pll_lock,
    input wire logic reg_req,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic acc_busy,
    input wire logic acc_done,
    input wire logic [23:0] expansion_address_pins_in,
    input wire logic expansion_address_pins_oe,
    input wire logic [3:0] exp_cs_n,
    input wire logic exp_rd_n,
    input wire logic exp_ale,
    input wire exp_cfg_pkg::strap_cfg_t strap_cfg,
    input wire logic [31:0] exp_window_base
);
    import exp_cfg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
////////////////////
    property p_ack;
        reg_ack == $past(reg_req);
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_cs_zero;
        reg_req && reg_addr[31:4] == 28'hC40_0000 |=> (reg_rdata & 32'h4000_82A4) == '0;
    endproperty
    a_cs_zero: assert property (p_cs_zero) else $error("fixed control bit set");
    // The base is registered in the same cycle as the map bit, so two stable cycles are margin only.
    property p_map;
        $stable(strap_cfg.mem_map_boot) ##1 $stable(strap_cfg.mem_map_boot) |->
            exp_window_base == (strap_cfg.mem_map_boot ? 32'h0000_0000 : 32'h5000_0000);
    endproperty
    a_map: assert property (p_map) else $error("window base wrong");
    property p_pin_dir;
        !$past(rst) |-> expansion_address_pins_oe == $past(pll_lock);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");
    property p_capture;
        !pll_lock |=> {3'h0, strap_cfg[20:0]} ==
            ($past(expansion_address_pins_in) & 24'h1F_FFFF);
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured");
    property p_one_sel;
        $onehot0(~exp_cs_n) && (exp_cs_n == 4'hF || acc_busy);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("select outside access");
    property p_ale;
        exp_ale |-> acc_busy && exp_cs_n == 4'hF && exp_rd_n;
    endproperty
    a_ale: assert property (p_ale) else $error("latch strobe outside address phase");
    property p_done;
        $fell(acc_busy) |-> acc_done ##1 !acc_done;
    endproperty
    a_done: assert property (p_done) else $error("done not a single pulse");
endmodule
bind exp_cfg_ctrl exp_cfg_asserts exp_cfg_asserts_i (.clk, .rst, .pll_lock, .reg_req,
    .reg_addr, .reg_rdata, .reg_ack, .acc_busy, .acc_done, .expansion_address_pins_in,
    .expansion_address_pins_oe, .exp_cs_n, .exp_rd_n, .exp_ale, .strap_cfg,
    .exp_window_base);
`default_nettype wire

// File: test/exp_dev_model.sv
/* Peripheral on the expansion bus: read data is a function of the address.
   Assumes one select active at a time. */
`timescale 1ns/1ps
`default_nettype none
module exp_dev_model (
    // Bus pins
    input wire logic clk,
    input wire logic [3:0] exp_cs_n,
    input wire logic exp_rd_n,
    input wire logic exp_wr_n,
    input wire logic [15:0] exp_data_out,
    input wire logic exp_data_oe,
    input wire logic [23:0] addr,
    output logic [15:0] exp_data_in,
    output logic external_wait_input_n,
    // Bench side
    input wire logic [3:0] stall_n,
    output logic [15:0] wd
);
    logic [15:0] junk = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic sel;
    assign sel = exp_cs_n != 4'hF;
    // An undriven data bus toggles, so stale data never passes as a read.
    assign exp_data_in = (sel && !exp_rd_n) ? addr[15:0] ^ 16'h5A3C : junk;
    // The wait line is pulled up while this device is not selected.
    assign external_wait_input_n = !(sel && cnt < stall_n);
    always_ff @(posedge clk)
    begin
        junk <= ~junk;
        cnt <= !sel ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
        if (sel && !exp_wr_n && exp_data_oe)
        begin
            wd <= exp_data_out;
        end
    end
endmodule
`default_nettype wire

// File: test/expansion_bus_cs_config_regs_bench.sv
/* Self-checking bench for exp_cfg_ctrl with a bus peripheral model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_cs_config_regs_bench;
    import exp_cfg_pkg::*;
    logic clk = '0, rst = 1'b1, pll_lock = 1'b1, cold_reset_n = 1'b1;
    logic reg_req = '0, reg_write = '0, acc_req = '0, acc_write = '0;
    logic [31:0] reg_addr = '0, reg_wdata = '0, acc_addr = '0, reg_rdata, exp_window_base;
    logic [15:0] acc_wdata = '0, exp_data_in, exp_data_out, acc_rdata, wd, w, mk;
    logic [23:0] expansion_address_pins_in = 24'hFF_FF6F, expansion_address_pins_out;
    logic reg_ack, acc_busy, acc_done, acc_error, acc_split, expansion_address_pins_oe;
    logic exp_data_oe, exp_rd_n, exp_wr_n, exp_ale, external_wait_input_n;
    logic [3:0] exp_cs_n, stall_n = '0;
    logic [1:0] exp_drive;
    logic [31:0] cfg_m;
    logic [31:0] cs_m [4];
    strap_cfg_t strap_cfg;
    speed_t core_speed, spd = SPEED_667;
    cs_ctrl_t cc;
    int n_mismatch = 0, checks = 0, cyc = 0, lat, lat0, o;
    exp_cfg_ctrl exp_cfg_ctrl_i (.clk, .rst, .pll_lock, .cold_reset_n, .reg_req, .reg_write,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .acc_req, .acc_write, .acc_addr,
        .acc_wdata, .acc_busy, .acc_done, .acc_error, .acc_split, .acc_rdata,
        .expansion_address_pins_in, .expansion_address_pins_out, .expansion_address_pins_oe,
        .exp_data_in, .exp_data_out, .exp_data_oe, .exp_cs_n, .exp_rd_n, .exp_wr_n,
        .exp_ale, .external_wait_input_n, .strap_cfg, .core_speed, .exp_drive,
        .exp_window_base);
    exp_dev_model exp_dev_model_i (.clk, .exp_cs_n, .exp_rd_n, .exp_wr_n, .exp_data_out,
        .exp_data_oe, .addr(expansion_address_pins_out), .exp_data_in,
        .external_wait_input_n, .stall_n, .wd);
////////////////////
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
////////////////////
    // Writes hand back the old contents, so reads and writes share one expectation.
    task automatic rw(input logic wr, input logic [31:0] a, d);
        logic [31:0] m;
        m = a == STRAP_CFG0_ADDR ? cfg_m : (a[31:4] == 28'hC40_0000 ? cs_m[a[3:2]] : '0);
        reg_req <= 1'b1;
        reg_write <= wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_req <= 1'b0;
        @(posedge clk);
        check("ack", 32'(reg_ack), 32'h1);
        check("rdata", reg_rdata, m);
        if (wr && a == STRAP_CFG0_ADDR)
            cfg_m = d & CFG0_WR_MASK | cfg_m & ~CFG0_WR_MASK;
        else if (wr && a[31:4] == 28'hC40_0000)
            cs_m[a[3:2]] = d & CS_WR_MASK | cs_m[a[3:2]] & ~CS_WR_MASK;
    endtask
    // Returns after done or after 300 cycles, so control writes never meet a live transfer.
    task automatic acc(input logic wr, input logic [31:0] a, input logic [15:0] d);
        acc_req <= 1'b1;
        acc_write <= wr;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge clk);
        acc_req <= 1'b0;
        lat = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end
        while (acc_done !== 1'b1 && lat < 300);
    endtask
    task automatic strap(input logic [23:0] p, input logic cold);
        pll_lock <= 1'b0;
        cold_reset_n <= !cold;
        expansion_address_pins_in <= p;
        repeat (3) @(posedge clk);
        pll_lock <= 1'b1;
        cold_reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        if (cold)
        begin
            cfg_m[23:21] = p[23:21];
            spd = (p[23] || !p[21]) ? SPEED_667 : (p[22] ? SPEED_400 : SPEED_533);
        end
        cfg_m = {8'h80, cfg_m[23:21], p[20:0]};
        cs_m[0][0] = p[0];
        check("strap", strap_cfg, cfg_m);
        check("speed", 32'(core_speed), 32'(spd));
        check("drive", 32'(exp_drive), 32'({p[9], p[5]}));
        rw(1'b0, STRAP_CFG0_ADDR, '0);
        rw(1'b0, CS_TIMING_ADDR, '0);
    endtask
////////////////////
    initial
    begin
        void'($urandom(32'h0000_4246));
        cs_m = '{32'hBFFF_3C00, '0, '0, '0};
        cfg_m = 32'h8000_0100;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++)
            rw(1'b0, 32'hC400_0000 + 4 * i, '0);
        for (int k = 0; k < 9; k++)
            strap({k[2:0], 21'($urandom)} & 24'hFF_FF6F | 24'h00_0008, k != 8);
        for (int i = 0; i < 18; i++)
        begin
            rw(1'b1, 32'hC400_0000 + 4 * (i % 9), $urandom & 32'hFFFF_FEBF);
            rw(1'b0, 32'hC400_0000 + 4 * (i % 9), '0);
        end
        rw(1'b1, STRAP_CFG0_ADDR, cfg_m & 32'h7FFF_FBFF | 32'h0000_0008);
        check("base", exp_window_base, 32'h5000_0000);
        cc = '0;
        cc.region_select_on = 1'b1;
        cc.write_allow = 1'b1;
        cc.region_size_code = 4'hF;
        rw(1'b1, 32'hC400_0004, cc);
        acc(1'b0, 32'h5100_0000, '0);
        lat0 = lat;
        for (int i = 0; i < 8; i++)
        begin
            cc = $urandom & 32'h3FFF_7C09 | 32'h8000_0002;
            if (cc.region_size_code == 4'hF)
                cc.region_size_code = 4'hE;
            rw(1'b1, 32'hC400_0004, cc);
            o = $urandom_range((1 << (9 + cc.region_size_code)) - 1) & ~1;
            mk = cc.narrow_bus ? 16'h00FF : 16'hFFFF;
            acc(1'b1, 32'h5100_0000 | o, o[15:0] ^ 16'h1234);
            check("wdata", 32'(wd & mk), 32'((o[15:0] ^ 16'h1234) & mk));
            acc(1'b0, 32'h5100_0000 | o, '0);
            check("rd", 32'({acc_error, acc_rdata}), 32'((o[15:0] ^ 16'h5A3C) & mk));
            check("split", 32'(acc_split), 32'(cc.split_response_allow));
            check("lat", lat, lat0 + cc.address_phase_stretch + cc.setup_phase_stretch
                + cc.strobe_phase_stretch + cc.hold_phase_stretch
                + cc.recovery_phase_stretch);
            acc(1'b0, 32'h5100_0000 + (1 << (9 + cc.region_size_code)), '0);
            check("range", 32'({acc_error, lat[3:0]}), 32'h11);
        end
        cc = '0;
        cc.region_select_on = 1'b1;
        cc.region_size_code = 4'hF;
        cc.shared_addr_data_bus = 1'b1;
        rw(1'b1, 32'hC400_0004, cc);
        acc(1'b0, 32'h5100_0000, '0);
        check("mux", 32'({acc_error, lat[7:0]}), 32'(lat0[7:0]));
        w = wd;
        acc(1'b1, 32'h5100_0010, ~w);
        check("blocked", 32'({acc_error, wd}), 32'({1'b1, w}));
        cc.region_select_on = 1'b0;
        rw(1'b1, 32'hC400_0004, cc);
        acc(1'b0, 32'h5100_0000, '0);
        check("off", 32'(acc_error), 32'h1);
        // Short phases, so the model's stall still stands when the strobe ends.
        rw(1'b1, CS_TIMING_ADDR, 32'h8000_3C00);
        stall_n <= 4'h4;
        acc(1'b0, 32'h5000_0000, '0);
        o = lat;
        rw(1'b1, STRAP_CFG0_ADDR, cfg_m | 32'h0000_0400);
        acc(1'b0, 32'h5000_0000, '0);
        check("wait", 32'(lat > o), 32'h1);
        rw(1'b1, CS_TIMING_ADDR, 32'h8000_3D00);
        acc(1'b0, 32'h5000_0000, '0);
        check("sync", lat, o);
        results();
    end
endmodule
`default_nettype wire
